/* File: acl_pkg.sv */
// Purpose: shared constants and types for the ipv6/icmp access control entry
// Assumes: apb byte addresses, 32-bit data
// Notes: register map and field positions used by rtl and bench
package acl_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_NH_VAL = 8'h04;
    localparam logic [7:0] OFF_ICMP_VAL = 8'h08;
    localparam logic [7:0] OFF_SRC_ADDR = 8'h0c;
    localparam logic [7:0] OFF_SRC_MASK = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_HIT_CNT = 8'h18;
    localparam logic [7:0] OFF_FRM_CNT = 8'h1c;
    // control field positions
    localparam int CTRL_NH_LSB = 0;
    localparam int CTRL_SRC_BIT = 3;
    localparam int CTRL_HOP_LSB = 4;
    localparam int CTRL_ITYPE_BIT = 6;
    localparam int CTRL_ICODE_BIT = 7;
    localparam int CTRL_EN_BIT = 8;
    localparam int ICMP_CODE_LSB = 8;
    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] VAL_RST = 32'h0000_0000;
    localparam logic [31:0] MASK_RST = 32'hffff_ffff;
    // next header protocol numbers
    localparam logic [7:0] PROTO_ICMPV6 = 8'h3a;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [7:0] PROTO_TCP = 8'h06;

    typedef enum logic [2:0] {
        NH_ANY = 3'b000,
        NH_SPECIFIC = 3'b001,
        NH_ICMP = 3'b010,
        NH_UDP = 3'b011,
        NH_TCP = 3'b100
    } nh_mode_t;

    typedef enum logic [1:0] {
        HOP_ANY = 2'b00,
        HOP_ZERO = 2'b01,
        HOP_NONZERO = 2'b10
    } hop_mode_t;

    typedef struct packed {
        logic is_ipv6;
        logic [7:0] next_hdr;
        logic [127:0] src_addr;
        logic [7:0] hop_limit;
        logic [7:0] icmp_type;
        logic [7:0] icmp_code;
    } frame_hdr_t;
endpackage

/* File: byte_field_match.sv */
// Purpose: any/specific compare of one 8-bit header field
// Assumes: combinational, used inside a clocked parent
// Notes: any makes the field a don't-care
`timescale 1ns/1ns
`default_nettype none
module byte_field_match
    import acl_pkg::*;
(
    // setting
    input wire logic specific,
    input wire logic [7:0] value,
    // frame field
    input wire logic [7:0] field,
    // result
    output logic match
);
    assign match = !specific || (field == value);
endmodule
`default_nettype wire

/* File: masked_addr_match.sv */
// Purpose: network match of the low source address word under a care mask
// Assumes: combinational
// Notes: a mask bit at zero makes that address bit a don't-care
`timescale 1ns/1ns
`default_nettype none
module masked_addr_match
    import acl_pkg::*;
(
    // setting
    input wire logic specific,
    input wire logic [31:0] addr,
    input wire logic [31:0] care_mask,
    // frame field
    input wire logic [127:0] src_addr,
    // result
    output logic match
);
    wire logic [31:0] low_word;

    assign low_word = src_addr[31:0];
    assign match = !specific || ((low_word & care_mask) == (addr & care_mask));
endmodule
`default_nettype wire

/* File: ipv6_icmp_acl_matcher.sv */
// Purpose: one access_control_entry for ipv6 frames with icmp criteria
// Assumes: parsed header fields arrive with a one-cycle valid strobe
// Notes: verdict one cycle after the strobe; settings over apb
//
// What this block does
// - next-header mode any ignores the next header field.
// - next-header mode specific matches only the configured 8-bit value.
// - next-header mode icmp needs icmpv6 and applies icmp type and code.
// - next-header mode udp needs udp as next header.
// - next-header mode tcp needs tcp as next header.
// - source_addr_filter any ignores the source address.
// - source_addr_filter specific is a masked network compare.
// - only the low 32 source address bits take part.
// - hop mode zero rejects frames with hop limit above zero.
// - hop mode non-zero matches frames with hop limit above zero.
// - hop mode any ignores the hop limit.
// - icmp type any ignores the icmp type.
// - icmp type specific matches only the configured 8-bit type, in next-header mode icmp only.
// - icmp code any ignores the icmp code.
// - icmp code specific matches only the configured 8-bit code, in next-header mode icmp only.
`timescale 1ns/1ns
`default_nettype none
module ipv6_icmp_acl_matcher
    import acl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // parsed frame header
    input wire logic frm_valid,
    input wire frame_hdr_t frm,
    // verdict
    output logic verdict_valid,
    output logic verdict_hit
);
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wdata,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] nh_val_q, nh_val_d;
    logic [31:0] icmp_val_q, icmp_val_d;
    logic [31:0] src_addr_q, src_addr_d;
    logic [31:0] src_mask_q, src_mask_d;
    logic [31:0] hit_cnt_q, hit_cnt_d;
    logic [31:0] frm_cnt_q, frm_cnt_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic verdict_valid_q, verdict_valid_d;
    logic verdict_hit_q, verdict_hit_d;
    logic last_ipv6_q, last_ipv6_d;

    // apb decode
    wire logic acc_start;
    wire logic acc_done;
    wire logic wr_done;
    wire logic sel_ctrl;
    wire logic sel_nh;
    wire logic sel_icmp;
    wire logic sel_saddr;
    wire logic sel_smask;
    wire logic sel_status;
    wire logic sel_hcnt;
    wire logic sel_fcnt;
    wire logic addr_ok;
    wire logic [31:0] rd_mux;

    assign acc_start = psel && penable && !pready_q;
    assign acc_done = psel && penable && pready_q;
    assign wr_done = acc_done && pwrite && !pslverr_q;
    assign sel_ctrl = (paddr == OFF_CTRL);
    assign sel_nh = (paddr == OFF_NH_VAL);
    assign sel_icmp = (paddr == OFF_ICMP_VAL);
    assign sel_saddr = (paddr == OFF_SRC_ADDR);
    assign sel_smask = (paddr == OFF_SRC_MASK);
    assign sel_status = (paddr == OFF_STATUS);
    assign sel_hcnt = (paddr == OFF_HIT_CNT);
    assign sel_fcnt = (paddr == OFF_FRM_CNT);
    assign addr_ok = sel_ctrl || sel_nh || sel_icmp || sel_saddr || sel_smask
                     || sel_status || sel_hcnt || sel_fcnt;

    assign rd_mux = sel_ctrl ? ctrl_q
                    : sel_nh ? nh_val_q
                    : sel_icmp ? icmp_val_q
                    : sel_saddr ? src_addr_q
                    : sel_smask ? src_mask_q
                    : sel_status ? {29'h0000_0000, last_ipv6_q, verdict_hit_q, verdict_valid_q}
                    : sel_hcnt ? hit_cnt_q
                    : sel_fcnt ? frm_cnt_q
                    : 32'h0000_0000;

    // settings view
    wire nh_mode_t nh_mode;
    wire hop_mode_t hop_mode;
    wire logic src_specific;
    wire logic itype_specific;
    wire logic icode_specific;
    wire logic entry_en;

    assign nh_mode = nh_mode_t'(ctrl_q[CTRL_NH_LSB +: 3]);
    assign hop_mode = hop_mode_t'(ctrl_q[CTRL_HOP_LSB +: 2]);
    assign src_specific = ctrl_q[CTRL_SRC_BIT];
    assign itype_specific = ctrl_q[CTRL_ITYPE_BIT];
    assign icode_specific = ctrl_q[CTRL_ICODE_BIT];
    assign entry_en = ctrl_q[CTRL_EN_BIT];

    // per-criterion matches
    wire logic nh_val_match;
    wire logic itype_match;
    wire logic icode_match;
    wire logic src_match;
    logic nh_match;
    logic hop_match;
    wire logic icmp_frame;
    wire logic icmp_match;
    wire logic frame_hit;

    byte_field_match u_nh_match (
        .specific(1'b1),
        .value(nh_val_q[7:0]),
        .field(frm.next_hdr),
        .match(nh_val_match)
    );

    byte_field_match u_itype_match (
        .specific(itype_specific),
        .value(icmp_val_q[7:0]),
        .field(frm.icmp_type),
        .match(itype_match)
    );

    byte_field_match u_icode_match (
        .specific(icode_specific),
        .value(icmp_val_q[ICMP_CODE_LSB +: 8]),
        .field(frm.icmp_code),
        .match(icode_match)
    );

    masked_addr_match u_src_match (
        .specific(src_specific),
        .addr(src_addr_q),
        .care_mask(src_mask_q),
        .src_addr(frm.src_addr),
        .match(src_match)
    );

    assign icmp_frame = frm.is_ipv6 && (frm.next_hdr == PROTO_ICMPV6);
    assign icmp_match = icmp_frame && itype_match && icode_match;

    always_comb begin
        nh_match = 1'b0;
        unique case (nh_mode)
            NH_ANY: nh_match = 1'b1;
            NH_SPECIFIC: nh_match = nh_val_match;
            NH_ICMP: nh_match = icmp_match;
            NH_UDP: nh_match = (frm.next_hdr == PROTO_UDP);
            NH_TCP: nh_match = (frm.next_hdr == PROTO_TCP);
            default: nh_match = 1'b0;
        endcase
    end

    always_comb begin
        hop_match = 1'b0;
        unique case (hop_mode)
            HOP_ANY: hop_match = 1'b1;
            HOP_ZERO: hop_match = (frm.hop_limit == 8'h00);
            HOP_NONZERO: hop_match = (frm.hop_limit != 8'h00);
            default: hop_match = 1'b0;
        endcase
    end

    // all criteria on one ipv6 frame
    assign frame_hit = entry_en && frm.is_ipv6 && nh_match && src_match && hop_match;

    // next-state
    always_comb begin
        ctrl_d = ctrl_q;
        nh_val_d = nh_val_q;
        icmp_val_d = icmp_val_q;
        src_addr_d = src_addr_q;
        src_mask_d = src_mask_q;
        hit_cnt_d = hit_cnt_q;
        frm_cnt_d = frm_cnt_q;
        if (wr_done && sel_ctrl) begin
            ctrl_d = merge_strb(ctrl_q, pwdata, pstrb) & 32'h0000_01ff;
        end
        if (wr_done && sel_nh) begin
            nh_val_d = merge_strb(nh_val_q, pwdata, pstrb) & 32'h0000_00ff;
        end
        if (wr_done && sel_icmp) begin
            icmp_val_d = merge_strb(icmp_val_q, pwdata, pstrb) & 32'h0000_ffff;
        end
        if (wr_done && sel_saddr) begin
            src_addr_d = merge_strb(src_addr_q, pwdata, pstrb);
        end
        if (wr_done && sel_smask) begin
            src_mask_d = merge_strb(src_mask_q, pwdata, pstrb);
        end
        // counter clear on write, a frame counted in the same cycle adds one after the clear
        if (wr_done && sel_hcnt) begin
            hit_cnt_d = 32'h0000_0000;
        end
        if (wr_done && sel_fcnt) begin
            frm_cnt_d = 32'h0000_0000;
        end
        if (frm_valid) begin
            frm_cnt_d = frm_cnt_d + 32'h0000_0001;
        end
        if (frm_valid && frame_hit) begin
            hit_cnt_d = hit_cnt_d + 32'h0000_0001;
        end
    end

    assign pready_d = acc_start;
    assign pslverr_d = acc_start ? !addr_ok : 1'b0;
    assign prdata_d = (acc_start && !pwrite) ? rd_mux : 32'h0000_0000;
    assign verdict_valid_d = frm_valid;
    assign verdict_hit_d = frm_valid && frame_hit;
    assign last_ipv6_d = frm_valid ? frm.is_ipv6 : last_ipv6_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q <= CTRL_RST;
            nh_val_q <= VAL_RST;
            icmp_val_q <= VAL_RST;
            src_addr_q <= VAL_RST;
            src_mask_q <= MASK_RST;
            hit_cnt_q <= VAL_RST;
            frm_cnt_q <= VAL_RST;
        end else begin
            ctrl_q <= ctrl_d;
            nh_val_q <= nh_val_d;
            icmp_val_q <= icmp_val_d;
            src_addr_q <= src_addr_d;
            src_mask_q <= src_mask_d;
            hit_cnt_q <= hit_cnt_d;
            frm_cnt_q <= frm_cnt_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            verdict_valid_q <= 1'b0;
            verdict_hit_q <= 1'b0;
            last_ipv6_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            verdict_valid_q <= verdict_valid_d;
            verdict_hit_q <= verdict_hit_d;
            last_ipv6_q <= last_ipv6_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign verdict_valid = verdict_valid_q;
    assign verdict_hit = verdict_hit_q;

    non_ipv6_miss_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        frm_valid && !frm.is_ipv6 |=> verdict_valid && !verdict_hit)
        else $error("non-ipv6 frame hit");

    nh_specific_miss_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        frm_valid && nh_mode == NH_SPECIFIC && frm.next_hdr != nh_val_q[7:0]
        |=> !verdict_hit)
        else $error("next header mismatch hit");

    nh_icmp_only_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        frm_valid && nh_mode == NH_ICMP && frm.next_hdr != PROTO_ICMPV6
        |=> !verdict_hit)
        else $error("icmp mode hit on non-icmp frame");

    nh_l4_gate_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        verdict_hit && $past(nh_mode) inside {NH_UDP, NH_TCP}
        |-> $past(frm.next_hdr) == (($past(nh_mode) == NH_UDP) ? PROTO_UDP : PROTO_TCP))
        else $error("l4 protocol gate broken");

    src_mask_cmp_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        verdict_hit && $past(src_specific)
        |-> (($past(frm.src_addr[31:0]) ^ $past(src_addr_q)) & $past(src_mask_q))
            == 32'h0000_0000)
        else $error("masked source mismatch hit");

    hop_zero_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        frm_valid && hop_mode == HOP_ZERO && frm.hop_limit != 8'h00 |=> !verdict_hit)
        else $error("zero hop mode hit on nonzero hop");

    icmp_fields_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        verdict_hit && $past(nh_mode) == NH_ICMP && $past(icode_specific)
        |-> $past(frm.icmp_code) == $past(icmp_val_q[ICMP_CODE_LSB +: 8]))
        else $error("icmp code mismatch hit");

    all_match_hit_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        frm_valid && entry_en && frm.is_ipv6 && nh_mode == NH_ANY
        && !src_specific && hop_mode == HOP_ANY |=> verdict_hit)
        else $error("all-any entry missed ipv6 frame");

    apb_answer_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("apb answer timing wrong");

    hit_count_a: assert property (
        @(posedge clk_sys) disable iff (srst)
        verdict_hit && !$past(wr_done && sel_hcnt)
        |-> hit_cnt_q == $past(hit_cnt_q) + 32'h0000_0001)
        else $error("hit counter not stepped");
endmodule
`default_nettype wire

/* File: frame_src_model.sv */
// Purpose: model of the ingress parser that hands parsed ipv6 headers to the entry
// Assumes: one header per send request, one-cycle valid strobe
// Notes: outside a strobe the header lines toggle so stale values never look valid
`timescale 1ns/1ns
`default_nettype none
module frame_src_model
    import acl_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // bench request
    input wire logic send,
    input wire frame_hdr_t hdr,
    // parsed header out
    output logic frm_valid,
    output frame_hdr_t frm
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frm_valid <= 1'b0;
            frm <= '0;
        end else if (send) begin
            frm_valid <= 1'b1;
            frm <= hdr;
        end else begin
            frm_valid <= 1'b0;
            frm <= ~frm;
        end
    end
endmodule
`default_nettype wire

/* File: ipv6_icmp_acl_matcher_bench.sv */
// Purpose: self-checking bench for the ipv6/icmp access control entry
// Assumes: apb answer and verdict timing as handed over
// Notes: random settings and frames from a fixed seed, plus corner cases
`timescale 1ns/1ns
`default_nettype none
module ipv6_icmp_acl_matcher_bench import acl_pkg::*;;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic send = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, frm_valid, verdict_valid, verdict_hit, er, hit;
    frame_hdr_t frm;
    frame_hdr_t hdr = '0;
    logic [31:0] cfg [5];
    logic [31:0] rd;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int hits, nfr;

    always #20 clk_sys = ~clk_sys;

    frame_src_model SRC (.clk_sys(clk_sys), .srst(srst), .send(send), .hdr(hdr),
        .frm_valid(frm_valid), .frm(frm));
    ipv6_icmp_acl_matcher DUT (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .frm_valid(frm_valid),
        .frm(frm), .verdict_valid(verdict_valid), .verdict_hit(verdict_hit));

    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic set_cfg(input logic [31:0] c, nv, iv, a, m);
        logic [7:0] offs [5];
        offs = '{OFF_CTRL, OFF_NH_VAL, OFF_ICMP_VAL, OFF_SRC_ADDR, OFF_SRC_MASK};
        cfg = '{c, nv, iv, a, m};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, offs[i], cfg[i]);
        end
    endtask

    task automatic frame(input frame_hdr_t h);
        int n;
        n = 0;
        @(posedge clk_sys);
        send <= 1'b1;
        hdr <= h;
        @(posedge clk_sys);
        send <= 1'b0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (verdict_valid !== 1'b1 && n < 8);
        hit = verdict_hit;
        cmp_bit(verdict_valid, 1'b1);
        // one cycle in the parser model plus one cycle to the verdict
        cmp_word(32'(n), 32'h0000_0002);
    endtask

    function automatic logic ref_hit(frame_hdr_t f);
        logic nh, src, hop, it, ic, icmp;
        icmp = f.next_hdr == PROTO_ICMPV6 && cfg[0][2:0] == 3'd2;
        case (cfg[0][2:0])
            3'd0: nh = 1'b1;
            3'd1: nh = f.next_hdr == cfg[1][7:0];
            3'd2: nh = f.next_hdr == PROTO_ICMPV6;
            3'd3: nh = f.next_hdr == PROTO_UDP;
            3'd4: nh = f.next_hdr == PROTO_TCP;
            default: nh = 1'b0;
        endcase
        src = !cfg[0][CTRL_SRC_BIT] || (f.src_addr[31:0] & cfg[4]) == (cfg[3] & cfg[4]);
        case (cfg[0][5:4])
            2'd0: hop = 1'b1;
            2'd1: hop = f.hop_limit == 8'h00;
            2'd2: hop = f.hop_limit != 8'h00;
            default: hop = 1'b0;
        endcase
        it = !(icmp && cfg[0][CTRL_ITYPE_BIT]) || f.icmp_type == cfg[2][7:0];
        ic = !(icmp && cfg[0][CTRL_ICODE_BIT]) || f.icmp_code == cfg[2][15:8];
        return cfg[0][CTRL_EN_BIT] && f.is_ipv6 && nh && src && hop && it && ic;
    endfunction

    function automatic frame_hdr_t rnd_frame();
        frame_hdr_t f;
        logic [7:0] nhs [5];
        nhs = '{cfg[1][7:0], PROTO_ICMPV6, PROTO_UDP, PROTO_TCP, 8'($urandom)};
        f.is_ipv6 = $urandom_range(7) != 0;
        f.next_hdr = nhs[$urandom_range(4)];
        f.src_addr = {$urandom, $urandom, $urandom, $urandom};
        if ($urandom_range(1) == 1) begin
            f.src_addr[31:0] = (cfg[3] & cfg[4]) | (f.src_addr[31:0] & ~cfg[4]);
        end
        f.hop_limit = ($urandom_range(1) == 1) ? 8'h00 : 8'($urandom);
        f.icmp_type = ($urandom_range(1) == 1) ? cfg[2][7:0] : 8'($urandom);
        f.icmp_code = ($urandom_range(1) == 1) ? cfg[2][15:8] : 8'($urandom);
        return f;
    endfunction

    initial begin
        frame_hdr_t f;
        logic [31:0] expv [8];
        logic [7:0] nhv [4];
        logic [31:0] lo [4];
        logic [7:0] hopv [3];
        expv = '{CTRL_RST, VAL_RST, VAL_RST, VAL_RST, MASK_RST, 32'h0, 32'h0, 32'h0};
        nhv = '{8'h2b, PROTO_ICMPV6, PROTO_UDP, PROTO_TCP};
        lo = '{32'h2, 32'h3, 32'h1, 32'h8000_0003};
        hopv = '{8'h00, 8'h01, 8'hff};
        void'($urandom(32'h9f0c3c3d));
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            cmp_word(rd, expv[i]);
        end
        apb(1'b1, OFF_STATUS, 32'hffff_ffff);
        apb(1'b0, OFF_STATUS, 32'h0);
        cmp_word(rd, 32'h0);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        cmp_bit(er, 1'b1);
        apb(1'b0, 8'h20, 32'h0);
        cmp_word(rd, 32'h0);
        // byte strobes: only byte 1 of the icmp value lands
        pstrb <= 4'h2;
        apb(1'b1, OFF_ICMP_VAL, 32'h1234_5678);
        pstrb <= 4'hf;
        apb(1'b0, OFF_ICMP_VAL, 32'h0);
        cmp_word(rd, 32'h0000_5600);
        $display("test registers done");
        set_cfg(32'h108, 32'h0, 32'h0, 32'h3, 32'hffff_fffe);
        for (int i = 0; i < 4; i++) begin
            f = rnd_frame();
            f.is_ipv6 = 1'b1;
            f.src_addr[31:0] = lo[i];
            frame(f);
            cmp_bit(hit, ref_hit(f));
        end
        $display("test source mask done");
        for (int md = 0; md < 8; md++) begin
            set_cfg(32'h100 | md, 32'h2b, 32'h0, 32'h0, 32'hffff_ffff);
            for (int j = 0; j < 4; j++) begin
                f = rnd_frame();
                f.is_ipv6 = 1'b1;
                f.next_hdr = nhv[j];
                frame(f);
                cmp_bit(hit, ref_hit(f));
            end
        end
        $display("test next header done");
        for (int md = 0; md < 4; md++) begin
            set_cfg(32'h100 | (md << 4), 32'h0, 32'h0, 32'h0, 32'hffff_ffff);
            for (int j = 0; j < 3; j++) begin
                f = rnd_frame();
                f.is_ipv6 = 1'b1;
                f.hop_limit = hopv[j];
                frame(f);
                cmp_bit(hit, ref_hit(f));
            end
        end
        $display("test hop limit done");
        for (int md = 0; md < 4; md++) begin
            set_cfg(32'h102 | (md << 6), 32'h0, $urandom, 32'h0, 32'hffff_ffff);
            repeat (6) begin
                f = rnd_frame();
                f.next_hdr = PROTO_ICMPV6;
                frame(f);
                cmp_bit(hit, ref_hit(f));
            end
        end
        $display("test icmp fields done");
        apb(1'b1, OFF_HIT_CNT, 32'h0);
        apb(1'b1, OFF_FRM_CNT, 32'h0);
        hits = 0;
        nfr = 0;
        repeat (20) begin
            set_cfg({23'h0, $urandom_range(3) != 0, 8'($urandom)}, $urandom, $urandom,
                $urandom, $urandom);
            repeat (10) begin
                f = rnd_frame();
                frame(f);
                cmp_bit(hit, ref_hit(f));
                hits += int'(ref_hit(f));
                nfr++;
            end
        end
        apb(1'b0, OFF_HIT_CNT, 32'h0);
        cmp_word(rd, 32'(hits));
        apb(1'b0, OFF_FRM_CNT, 32'h0);
        cmp_word(rd, 32'(nfr));
        $display("test random done");
        final_report();
    end
endmodule
`default_nettype wire
